// file: rtl/ifd_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "ifd_defs.svh"

module ifd_decoder (
  input  wire logic                    clk_sys_i,     // core clock
  input  wire logic                    rstn_i,        // sync reset, active low
  input  wire logic [`IFD_INSN_W-1:0]  insn_i,        // fetched word
  input  wire logic                    insn_valid_i,  // word present at last phase (3)
  input  wire logic                    branch_i,      // executing word taken or pc changed
  output logic                         fetch_o,       // pulse: take next word
  output logic [1:0]                   phase_o,       // current phase
  output logic                         cyc_end_o,     // pulse on last phase
  output logic                         nop_o,         // current cycle is forced nop
  output logic                         exec_o,        // valid decode executing
  output ifd_pkg::ifd_dec_s            dec_o          // decoded fields
);

  // phase counter
  logic [2:0]         ph_r;
  logic [2:0]         ph_nxt;
  // pending forced nop, active word flags
  logic               nop_r;
  logic               nop_nxt;
  logic               exec_r;
  logic               exec_nxt;
  ifd_pkg::ifd_dec_s  dec_r;
  logic               fetch_r;
  logic               cend_r;

  // decode function, used for the issuing word
  function automatic ifd_pkg::ifd_dec_s decode(input logic [`IFD_INSN_W-1:0] w);
    ifd_pkg::ifd_dec_s d;
    d = '0;
    // operand fields are cut out unconditionally; the format picks which matter
    d.file_addr = w[`IFD_FILE_HI:0];
    d.bit_num   = w[`IFD_BIT_B_HI:`IFD_BIT_B_LO];
    d.lit8      = w[`IFD_LIT8_HI:0];
    d.lit11     = w[`IFD_LIT11_HI:0];
    d.dest_file = w[`IFD_BYTE_D_POS];
    // class lives in the top two bits of every word
    case (w[13:12])
      // byte format: six opcode bits fill the field exactly
      `IFD_CLS_BYTE: begin
        d.fmt    = ifd_pkg::IFD_FMT_BYTE;
        d.opcode = w[`IFD_OP_HI:`IFD_BYTE_OP_LO];
      end
      // bit format: four opcode bits, right aligned
      `IFD_CLS_BIT: begin
        d.fmt    = ifd_pkg::IFD_FMT_BIT;
        d.opcode = {2'h0, w[`IFD_OP_HI:`IFD_BIT_OP_LO]};
      end
      // call and jump: three opcode bits, eleven-bit target
      `IFD_CLS_JMP: begin
        d.fmt    = ifd_pkg::IFD_FMT_JMP;
        d.opcode = {3'h0, w[`IFD_OP_HI:`IFD_JMP_OP_LO]};
      end
      // general literal and control words
      default: begin
        d.fmt    = ifd_pkg::IFD_FMT_LIT;
        d.opcode = w[`IFD_OP_HI:`IFD_LIT_OP_LO];
      end
    endcase
    // dest bit only meaningful for byte format; others ignore it
    if (d.fmt != ifd_pkg::IFD_FMT_BYTE) begin
      d.dest_file = 1'h0;
    end
    // bit number only meaningful for bit format
    if (d.fmt != ifd_pkg::IFD_FMT_BIT) begin
      d.bit_num = 3'h0;
    end
    return d;
  endfunction : decode

  // phase and cycle decode
  // executing word asked for a nop follow-up cycle
  wire nop_nxt_gate = exec_r && branch_i;
  // last phase of the instruction cycle
  wire last_ph      = (ph_r == (`IFD_PHASES - 3'h1));
  // a word is taken only when offered and not refused
  wire issue_ok     = last_ph && insn_valid_i && !nop_nxt_gate;
  // counter steps every clock and wraps at the boundary
  assign ph_nxt   = last_ph ? 3'h0 : (ph_r + 3'h1);
  // next cycle is nop when the executing word branched
  assign nop_nxt  = last_ph ? nop_nxt_gate : nop_r;
  assign exec_nxt = last_ph ? issue_ok : exec_r;

  // phase counter and sequencing flags
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ph_r   <= 3'h0;
      nop_r  <= `IFD_NOP_RST;
      exec_r <= 1'h0;
    end else begin
      ph_r   <= ph_nxt;
      nop_r  <= nop_nxt;
      exec_r <= exec_nxt;
    end
  end

  // decoded word latched at cycle boundary
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      dec_r <= '0;
    end else if (last_ph) begin
      dec_r <= issue_ok ? decode(insn_i) : '0;
    end
  end

  // pulse outputs registered
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      fetch_r <= 1'h0;
      cend_r  <= 1'h0;
    end else begin
      fetch_r <= (ph_nxt == (`IFD_PHASES - 3'h2));
      cend_r  <= (ph_nxt == (`IFD_PHASES - 3'h1));
    end
  end

  // outputs are the registers themselves, no logic behind them
  assign phase_o   = ph_r[1:0];
  assign fetch_o   = fetch_r;
  assign cyc_end_o = cend_r;
  assign nop_o     = nop_r;
  assign exec_o    = exec_r;
  assign dec_o     = dec_r;

  // phase counter wraps after four
  a_phase_wrap: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    last_ph |=> ph_r == 3'h0) else $error("phase did not wrap");
  a_phase_range: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ph_r < `IFD_PHASES) else $error("phase out of range");
  // one whole instruction cycle spent as a forced nop
  sequence s_nop_cycle;
    (nop_r && !exec_r)[*4];
  endsequence

  // word offered at the boundary and not refused
  sequence s_take;
    last_ph && insn_valid_i && !(exec_r && branch_i);
  endsequence

  // executing branch forces a nop cycle
  a_branch_nop: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (last_ph && exec_r && branch_i) |=> s_nop_cycle)
    else $error("branch did not insert nop");
  // no branch: next word executes directly
  a_single_cyc: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    s_take |=> exec_r && !nop_r)
    else $error("extra cycle without branch");
  // a refused word leaves the decode empty
  a_drop_word: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (last_ph && nop_nxt_gate) |=> dec_r == '0)
    else $error("refused word decoded");
  // flags move only at the cycle boundary
  a_flag_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !last_ph |=> $stable(exec_r) && $stable(nop_r))
    else $error("flag moved mid cycle");
  // no word taken means nothing executes
  a_one_word: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (last_ph && !issue_ok) |=> !exec_r)
    else $error("execute without a word");
  // destination bit follows word
  a_dest_sel: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (issue_ok && insn_i[13:12] == `IFD_CLS_BYTE) |=> dec_r.dest_file == $past(insn_i[7]))
    else $error("dest select wrong");
  // bit field taken from bits 9:7
  a_bit_field: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (issue_ok && insn_i[13:12] == `IFD_CLS_BIT) |=> dec_r.bit_num == $past(insn_i[9:7]))
    else $error("bit number wrong");
  // file address in low seven bits
  a_file_addr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    issue_ok |=> dec_r.file_addr == $past(insn_i[6:0]))
    else $error("file address wrong");
  // jump literal eleven bits
  a_jmp_lit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (issue_ok && insn_i[13:12] == `IFD_CLS_JMP) |=> dec_r.lit11 == $past(insn_i[10:0]))
    else $error("jump literal wrong");
  // literal-class dont-care bits do not leak
  a_dont_care: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (issue_ok && insn_i[13:12] == `IFD_CLS_LIT) |=> !dec_r.dest_file && dec_r.bit_num == 3'h0)
    else $error("dont care bit leaked");
  // fetch pulse one phase before boundary
  a_word_fetch: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    fetch_o |-> phase_o == 2'h2) else $error("fetch misplaced");
  // end pulse sits on the last phase only
  a_cyc_end: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cyc_end_o |-> phase_o == 2'h3) else $error("cycle end misplaced");
  // byte opcode is the top six bits
  a_byte_op: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (issue_ok && insn_i[13:12] == `IFD_CLS_BYTE) |=> dec_r.opcode == $past(insn_i[13:8]))
    else $error("byte opcode wrong");
  // general literal in the low eight bits
  a_lit_field: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (issue_ok && insn_i[13:12] == `IFD_CLS_LIT) |=> dec_r.lit8 == $past(insn_i[7:0]))
    else $error("literal wrong");

endmodule : ifd_decoder
`default_nettype wire

// file: shared/ifd_defs.svh
`ifndef IFD_DEFS_SVH
`define IFD_DEFS_SVH
// instruction word width
`define IFD_INSN_W       14
// phases per instruction cycle
`define IFD_PHASES       3'h4
// field positions
`define IFD_OP_HI        13
`define IFD_BYTE_OP_LO   8
`define IFD_BYTE_D_POS   7
`define IFD_BIT_OP_LO    10
`define IFD_BIT_B_HI     9
`define IFD_BIT_B_LO     7
`define IFD_LIT_OP_LO    8
`define IFD_JMP_OP_LO    11
`define IFD_FILE_HI      6
`define IFD_LIT8_HI      7
`define IFD_LIT11_HI     10
// top-two-bit class codes
`define IFD_CLS_BYTE     2'h0
`define IFD_CLS_BIT      2'h1
`define IFD_CLS_LIT      2'h3
`define IFD_CLS_JMP      2'h2
// destination select value meaning file register
`define IFD_DEST_FILE    1'h1
// reset value of the nop flag
`define IFD_NOP_RST      1'h0
`endif

// file: shared/ifd_pkg.sv
package ifd_pkg;
  // operand format of a decoded word
  typedef enum logic [1:0] {
    IFD_FMT_BYTE,
    IFD_FMT_BIT,
    IFD_FMT_LIT,
    IFD_FMT_JMP
  } ifd_fmt_e;

  // decoded instruction fields
  typedef struct packed {
    ifd_fmt_e    fmt;        // operand format
    logic [5:0]  opcode;     // opcode, right aligned
    logic        dest_file;  // 1: result to file register, 0: to accumulator
    logic [2:0]  bit_num;    // bit number for bit format
    logic [6:0]  file_addr;  // file register address
    logic [7:0]  lit8;       // general literal
    logic [10:0] lit11;      // branch literal
  } ifd_dec_s;
endpackage : ifd_pkg

// file: test/ifd_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
// program memory stand-in: answers each fetch pulse with one word while offer_i is high
module ifd_prog_mem (
  input  wire logic        clk_i,    // core clock
  input  wire logic        fetch_i,  // fetch pulse from decoder
  input  wire logic        offer_i,  // low: no word ready
  input  wire logic [13:0] word_i,   // word to hand over
  output logic      [13:0] insn_o,   // word on the bus
  output logic             valid_o   // bus holds a word
);
  initial begin
    insn_o  = 14'h0;
    valid_o = 1'h0;
  end
  // word stands one phase, then the bus toggles so stale data cannot pass
  always @(posedge clk_i) begin
    if (fetch_i && offer_i) begin
      insn_o  <= #1 word_i;
      valid_o <= #1 1'h1;
    end else begin
      insn_o  <= #1 ~insn_o;
      valid_o <= #1 1'h0;
    end
  end
endmodule : ifd_prog_mem
`default_nettype wire

// file: test/ifd_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ifd_decoder_tb;
  logic              clk_sys_i, rstn_i, branch_i, offer, insn_valid_i;
  logic              fetch_o, cyc_end_o, nop_o, exec_o;
  logic [13:0]       word, insn_i;
  logic [1:0]        phase_o, p;
  ifd_pkg::ifd_dec_s dec_o;
  int                err_count = 0;
  int                check_count = 0;
  // free-running core clock, 5 ns
  initial begin
    clk_sys_i = 1'h0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  ifd_decoder i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .insn_i(insn_i),
    .insn_valid_i(insn_valid_i), .branch_i(branch_i), .fetch_o(fetch_o), .phase_o(phase_o),
    .cyc_end_o(cyc_end_o), .nop_o(nop_o), .exec_o(exec_o), .dec_o(dec_o));
  ifd_prog_mem i_mem (.clk_i(clk_sys_i), .fetch_i(fetch_o), .offer_i(offer), .word_i(word),
    .insn_o(insn_i), .valid_o(insn_valid_i));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // step edges until the wanted phase shows, bounded
  task automatic wait_ph(input logic [1:0] ph);
    for (int n = 0; n < 8; n++) begin
      @(posedge clk_sys_i);
      #1;
      if (phase_o === ph) break;
    end
    chk(phase_o, ph);
  endtask : wait_ph
  // decoded fields of the executing word against its own bits
  task automatic chk_dec(input logic [13:0] w);
    chk({exec_o, nop_o}, 2'h2);
    case (w[13:12])
      2'h0: chk({dec_o.fmt, dec_o.opcode, dec_o.dest_file, dec_o.bit_num, dec_o.file_addr},
                {ifd_pkg::IFD_FMT_BYTE, w[13:8], w[7], 3'h0, w[6:0]});
      2'h1: chk({dec_o.fmt, dec_o.opcode, dec_o.dest_file, dec_o.bit_num, dec_o.file_addr},
                {ifd_pkg::IFD_FMT_BIT, 2'h0, w[13:10], 1'h0, w[9:7], w[6:0]});
      2'h3: chk({dec_o.fmt, dec_o.opcode, dec_o.dest_file, dec_o.bit_num, dec_o.lit8},
                {ifd_pkg::IFD_FMT_LIT, w[13:8], 4'h0, w[7:0]});
      default: chk({dec_o.fmt, dec_o.opcode, dec_o.dest_file, dec_o.bit_num, dec_o.lit11},
                   {ifd_pkg::IFD_FMT_JMP, 3'h0, w[13:11], 4'h0, w[10:0]});
    endcase
  endtask : chk_dec
  // offer one word and judge it in the cycle it executes
  task automatic run(input logic [13:0] w);
    word = w;
    wait_ph(2'h3);
    wait_ph(2'h0);
    chk_dec(w);
  endtask : run
  // phase walk, fetch and end-of-cycle pulses
  task automatic t_phases();
    for (int i = 0; i < 8; i++) begin
      p = phase_o;
      @(posedge clk_sys_i);
      #1;
      chk(phase_o, 2'(p + 2'h1));
      chk({fetch_o, cyc_end_o}, {phase_o == 2'h2, phase_o == 2'h3});
    end
  endtask : t_phases
  // taken branch: dropped word, nop cycle, then re-offer executes
  task automatic t_branch();
    branch_i = 1'h1;
    word     = 14'h30A5;
    wait_ph(2'h3);
    wait_ph(2'h0);
    branch_i = 1'h0;
    chk({nop_o, exec_o, dec_o}, {2'h2, 38'h0});
    run(14'h30A5);
  endtask : t_branch
  // no word offered: nothing executes
  task automatic t_idle();
    offer = 1'h0;
    wait_ph(2'h3);
    wait_ph(2'h0);
    chk(exec_o, 1'h0);
    offer = 1'h1;
  endtask : t_idle
  task automatic final_report();
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // watchdog well past the expected run length
  initial begin
    #20000;
    err_count++;
    final_report();
  end
  initial begin
    {rstn_i, branch_i, word, offer} = {1'h0, 1'h0, 14'h0, 1'h1};
    repeat (3) @(posedge clk_sys_i);
    #1 rstn_i = 1'h1;
    chk({exec_o, nop_o, fetch_o, cyc_end_o, phase_o, dec_o}, 64'h0);
    t_phases();
    run(14'h0785);
    run(14'h0A05);
    run(14'h1FFF);
    run(14'h30A5);
    run(14'h2ABC);
    t_branch();
    t_idle();
    final_report();
  end
endmodule : ifd_decoder_tb
`default_nettype wire
